// >>> rtl/bbsram_host.sv
// Host controller driving an asynchronous battery-backed byte SRAM
// Notes on behaviour
// RULE_01: Select low with strobe high reads the memory.
// RULE_02: Thirteen address bits pick one of 8,192 bytes.
// RULE_03: Memory drives the bus only when select and gate low outside writes.
// RULE_04: Read data valid after 70 ns address/select, 35 ns gate.
// RULE_05: Early enabled outputs are undefined until address access time.
// RULE_06: Address change holds old data 10 ns then undefined.
// RULE_07: Select and strobe both low means write, gate ignored.
// RULE_08: Write spans later falling edge to earlier rising edge.
// RULE_09: Host keeps address stable through write, valid 60 ns before end.
// RULE_10: Host sets write data 30 ns before end, holds 5 ns after.
// RULE_11: Host holds strobe 50 ns or select 55 ns low.
// RULE_12: Host raises select or strobe between accesses, cycles 70 ns apart.
// RULE_13: Host keeps gate high during writes.
// RULE_14: Falling strobe floats driven outputs within 25 ns.
// RULE_15: Select and strobe falling together never drive outputs.
// RULE_16: Supply fault deselects, blocks writes, ignores all inputs.
// RULE_17: Fault during a write may corrupt only that byte.
// RULE_18: Below switchover runs from battery and keeps all bytes.
// RULE_19: After supply returns, accesses ignored for a recovery interval.
// RULE_20: Fault and backup are level inputs; contents persist.
`include "bbsram_regs.svh"
module bbsram_host #(
   parameter int RECOVERY_CYC = `BBS_RECOVERY_CYC
) (
   // Clock and reset
   input  wire logic                   CLK,
   input  wire logic                   RST_N,
   // User request
   input  wire logic                   REQ_VALID,
   input  wire bbsram_pkg::bbs_req_s   REQ,
   output logic                        REQ_READY,
   output logic                        RD_VALID,
   output logic [`BBS_DATA_W-1:0]      RD_DATA,
   // Supply monitor level
   input  wire logic                   SUPPLY_FAULT,
   // Memory pins
   output logic [`BBS_ADDR_W-1:0]      BYTE_ADDR,
   output bbsram_pkg::bbs_ctl_s        CTL_N,
   input  wire logic [`BBS_DATA_W-1:0] BYTE_BUS_IN,
   output logic [`BBS_DATA_W-1:0]      BYTE_BUS_OUT,
   output logic                        BYTE_BUS_OE
);
   bbsram_pkg::bbs_state_e state;
   logic [2:0]             cnt;
   logic [31:0]            rec_cnt;
   logic                   rec_done;

   assign rec_done = (rec_cnt == 32'h0);

   // Recovery countdown restarts on every fault sample [RULE_19] [RULE_20]
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rec_cnt <= 32'h0;
      end else if (SUPPLY_FAULT) begin
         rec_cnt <= RECOVERY_CYC;
      end else if (!rec_done) begin
         rec_cnt <= rec_cnt - 32'h1;
      end
   end

   // Access sequencer; cnt is shared and each counting state clears it on exit
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state        <= bbsram_pkg::S_IDLE;
         cnt          <= 3'h0;
         REQ_READY    <= 1'b0;
         RD_VALID     <= 1'b0;
         RD_DATA      <= 8'h00;
         BYTE_ADDR    <= 13'h0000;
         CTL_N        <= 3'h7;
         BYTE_BUS_OUT <= 8'h00;
         BYTE_BUS_OE  <= 1'b0;
      end else begin
         RD_VALID  <= 1'b0;
         REQ_READY <= 1'b0;
         case (state)
            bbsram_pkg::S_IDLE: begin
               // A request held through a fault waits in S_WAIT for the whole recovery interval
               if (SUPPLY_FAULT || !rec_done) begin
                  state <= bbsram_pkg::S_WAIT; // [RULE_16] [RULE_19]
               end else if (REQ_VALID) begin
                  REQ_READY <= 1'b1;
                  BYTE_ADDR <= REQ.addr; // [RULE_02] [RULE_09]
                  cnt       <= 3'h0;
                  if (REQ.write) begin
                     // Gate stays high, data driven on the same edge the strobes fall [RULE_13] [RULE_07]
                     BYTE_BUS_OUT <= REQ.wdata;
                     BYTE_BUS_OE  <= 1'b1;
                     CTL_N        <= '{chip_sel_n: 1'b0, out_gate_n: 1'b1, wr_strobe_n: 1'b0}; // [RULE_08]
                     state        <= bbsram_pkg::S_WRSTB;
                  end else begin
                     CTL_N <= '{chip_sel_n: 1'b0, out_gate_n: 1'b0, wr_strobe_n: 1'b1}; // [RULE_01]
                     state <= bbsram_pkg::S_RDACC;
                  end
               end
            end
            bbsram_pkg::S_RDACC: begin
               cnt <= cnt + 3'h1;
               // Sample after the slowest access path plus margin [RULE_04] [RULE_05]
               if (cnt + 3'h1 == `BBS_ACCESS_CYC) begin
                  RD_DATA  <= BYTE_BUS_IN;
                  RD_VALID <= 1'b1;
                  CTL_N    <= 3'h7;
                  cnt      <= 3'h0;
                  state    <= bbsram_pkg::S_GAP;
               end
            end
            bbsram_pkg::S_WRSTB: begin
               cnt <= cnt + 3'h1;
               // Both strobes low long enough for either pulse width [RULE_11] [RULE_09] [RULE_10]
               // A fault here does not cut the pulse: the memory already ignores it
               if (cnt + 3'h1 == `BBS_STROBE_CYC) begin
                  CTL_N <= 3'h7; // [RULE_08] [RULE_12]
                  cnt   <= 3'h0;
                  state <= bbsram_pkg::S_WRHLD;
               end
            end
            bbsram_pkg::S_WRHLD: begin
               cnt <= cnt + 3'h1;
               // Data and address held past the write end [RULE_10]
               if (cnt + 3'h1 == `BBS_HOLD_CYC) begin
                  BYTE_BUS_OE <= 1'b0;
                  cnt         <= 3'h0;
                  state       <= bbsram_pkg::S_GAP;
               end
            end
            // All pins idle here, so back-to-back accesses keep the cycle spacing
            bbsram_pkg::S_GAP: begin
               cnt <= cnt + 3'h1;
               if (cnt + 3'h1 == `BBS_GAP_CYC) begin
                  cnt   <= 3'h0;
                  state <= bbsram_pkg::S_IDLE; // [RULE_12]
               end
            end
            bbsram_pkg::S_WAIT: begin
               if (!SUPPLY_FAULT && rec_done) begin
                  state <= bbsram_pkg::S_IDLE;
               end
            end
            default: begin
               state <= bbsram_pkg::S_IDLE;
            end
         endcase
      end
   end

   property p_gate_high_write;
      @(posedge CLK) disable iff (!RST_N)
         !CTL_N.wr_strobe_n |-> CTL_N.out_gate_n && BYTE_BUS_OE;
   endproperty
   a_gate_in_write: assert property (p_gate_high_write) // [RULE_13]
      else $error("Gate low or bus floating during a write");

   a_no_fault_access: assert property ( // [RULE_16]
      @(posedge CLK) disable iff (!RST_N)
         SUPPLY_FAULT && state == bbsram_pkg::S_IDLE |=> CTL_N.chip_sel_n)
      else $error("Access started during supply fault");

   // An access in flight when the fault hits ends within two cycles
   a_recovery_quiet: assert property ( // [RULE_19]
      @(posedge CLK) disable iff (!RST_N)
         !rec_done |=> CTL_N.chip_sel_n)
      else $error("Access launched inside the recovery interval");

   a_recovery_block: assert property ( // [RULE_19]
      @(posedge CLK) disable iff (!RST_N)
         $fell(SUPPLY_FAULT) |-> ##1 CTL_N.chip_sel_n [*2])
      else $error("Access inside recovery interval");

   // Write: select low with data on the bus, then both strobes rise one cycle later
   sequence s_wr_start;
      $fell(CTL_N.wr_strobe_n);
   endsequence
   sequence s_wr_low;
      !CTL_N.chip_sel_n && BYTE_BUS_OE;
   endsequence
   sequence s_wr_end;
      $rose(CTL_N.wr_strobe_n) && $rose(CTL_N.chip_sel_n) && $stable(BYTE_ADDR) && $stable(BYTE_BUS_OUT);
   endsequence
   a_write_pulse: assert property ( // [RULE_11]
      @(posedge CLK) disable iff (!RST_N)
         s_wr_start |-> s_wr_low ##1 s_wr_end)
      else $error("Write pulse wrong length or address moved");

   a_addr_in_write: assert property ( // [RULE_09]
      @(posedge CLK) disable iff (!RST_N)
         !CTL_N.wr_strobe_n |=> $stable(BYTE_ADDR))
      else $error("Address moved during a write");

   // The host must never fight the memory's output drivers
   a_gate_no_drive: assert property ( // [RULE_13]
      @(posedge CLK) disable iff (!RST_N)
         !CTL_N.out_gate_n |-> !BYTE_BUS_OE)
      else $error("Host drives the bus while the gate is low");

   a_data_hold: assert property ( // [RULE_10]
      @(posedge CLK) disable iff (!RST_N)
         $rose(CTL_N.wr_strobe_n) |-> BYTE_BUS_OE && $stable(BYTE_BUS_OUT))
      else $error("Write data not held after write end");

   a_read_mode: assert property ( // [RULE_01]
      @(posedge CLK) disable iff (!RST_N)
         state == bbsram_pkg::S_RDACC |-> !CTL_N.chip_sel_n && CTL_N.wr_strobe_n && !BYTE_BUS_OE)
      else $error("Read state without read mode pins");

   a_read_latency: assert property ( // [RULE_04]
      @(posedge CLK) disable iff (!RST_N)
         $fell(CTL_N.out_gate_n) |-> ##2 RD_VALID)
      else $error("Read sampled at wrong time");

   a_cycle_gap: assert property ( // [RULE_12]
      @(posedge CLK) disable iff (!RST_N)
         $rose(CTL_N.chip_sel_n) |-> CTL_N.chip_sel_n [*2])
      else $error("Accesses spaced too closely");

   // Shortest access is four cycles, so takes are at least that far apart
   a_ready_spacing: assert property ( // [RULE_12]
      @(posedge CLK) disable iff (!RST_N)
         REQ_READY |=> !REQ_READY [*3])
      else $error("Requests taken too close together");
endmodule : bbsram_host

// >>> rtl/bbsram_regs.svh
// Timing constants and widths for the battery-backed SRAM host port
`ifndef BBSRAM_REGS_SVH
`define BBSRAM_REGS_SVH
`define BBS_CLK_NS          100
`define BBS_ADDR_W          13
`define BBS_DATA_W          8
`define BBS_ACCESS_NS       70
`define BBS_GATE_ACCESS_NS  35
`define BBS_WE_PULSE_NS     50
`define BBS_CE_PULSE_NS     55
`define BBS_ADDR_SETUP_NS   60
`define BBS_DATA_SETUP_NS   30
`define BBS_DATA_HOLD_NS    5
`define BBS_CYCLE_NS        70
`define BBS_FLOAT_NS        25
`define BBS_RECOVERY_NS     1000
`define BBS_CEIL(t)         (((t) + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_ACCESS_CYC      3'(`BBS_CEIL(`BBS_ACCESS_NS) + 1)
`define BBS_STROBE_CYC      3'(`BBS_CEIL(`BBS_CE_PULSE_NS))
`define BBS_HOLD_CYC        3'(`BBS_CEIL(`BBS_DATA_HOLD_NS))
`define BBS_GAP_CYC         3'(`BBS_CEIL(`BBS_CYCLE_NS))
`define BBS_RECOVERY_CYC    `BBS_CEIL(`BBS_RECOVERY_NS)
`endif

// >>> rtl/bbsram_pkg.sv
// Types for the battery-backed SRAM host port
package bbsram_pkg;
   typedef enum logic [5:0] {
      S_IDLE  = 6'h01,
      S_RDACC = 6'h02,
      S_WRSTB = 6'h04,
      S_WRHLD = 6'h08,
      S_GAP   = 6'h10,
      S_WAIT  = 6'h20
   } bbs_state_e;
   typedef struct packed {
      logic        write;
      logic [12:0] addr;
      logic [7:0]  wdata;
   } bbs_req_s;
   typedef struct packed {
      logic       chip_sel_n;
      logic       out_gate_n;
      logic       wr_strobe_n;
   } bbs_ctl_s;
endpackage : bbsram_pkg

// >>> verification/bbsram_dev_model.sv
// Behavioural model of the battery-backed byte memory on the far side of the host port
module bbsram_dev_model #(
   parameter int ACCESS_NS = 70,
   parameter int REC_NS    = 1000
) (
   // Memory pins
   input  wire logic [12:0]          byte_addr,
   input  wire bbsram_pkg::bbs_ctl_s ctl_n,
   input  wire logic [7:0]           byte_bus,
   input  wire logic                 supply_fault,
   output logic [7:0]                mem_drv,
   output logic                      mem_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:8191];
   time        t_sel = 0;
   time        t_ok  = 0;
   logic       rec_wait = 1'b0;
   logic       dead;
   logic       wr_on;
   initial mem_drv = 8'h00;
   always @(negedge supply_fault) t_ok = $time + REC_NS;
   // A continuous assign never wakes on time alone, so the recovery window is polled
   always #5 rec_wait = ($time < t_ok);
   assign dead  = supply_fault || rec_wait;
   assign wr_on = !dead && !ctl_n.chip_sel_n && !ctl_n.wr_strobe_n;
   // Byte is taken at the end of the write, so a fault mid-write loses only it
   always @(negedge wr_on) if (!dead) mem[byte_addr] = byte_bus;
   always @(byte_addr or ctl_n) t_sel = $time;
   // Released or early data toggles, so a stale byte never passes for a match
   always #5 begin
      mem_oe = !dead && !ctl_n.chip_sel_n && !ctl_n.out_gate_n && ctl_n.wr_strobe_n;
      mem_drv = (mem_oe && $time - t_sel >= ACCESS_NS) ? mem[byte_addr] : ~mem_drv;
   end
endmodule : bbsram_dev_model

// >>> verification/battery_backed_async_sram_port_test.sv
// Self-checking bench for the battery-backed SRAM host port
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module battery_backed_async_sram_port_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 req_valid = 1'b0;
   bbsram_pkg::bbs_req_s req = '0;
   logic                 req_ready;
   logic                 rd_valid;
   logic [7:0]           rd_data;
   logic                 fault = 1'b0;
   logic [12:0]          addr;
   bbsram_pkg::bbs_ctl_s ctl_n;
   logic [7:0]           bus_out;
   logic                 bus_oe;
   logic [7:0]           mem_drv;
   logic                 mem_oe;
   int                   n_errors = 0;
   int                   cmp_count = 0;
   int                   cyc = 0;
   always #50 clk = ~clk;
   bbsram_host #(.RECOVERY_CYC(10)) u_dut (.CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ(req),
      .REQ_READY(req_ready), .RD_VALID(rd_valid), .RD_DATA(rd_data), .SUPPLY_FAULT(fault), .BYTE_ADDR(addr),
      .CTL_N(ctl_n), .BYTE_BUS_IN(bus_oe ? bus_out : mem_drv), .BYTE_BUS_OUT(bus_out), .BYTE_BUS_OE(bus_oe));
   bbsram_dev_model u_mem (.byte_addr(addr), .ctl_n(ctl_n), .byte_bus(bus_out), .supply_fault(fault),
      .mem_drv(mem_drv), .mem_oe(mem_oe));
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   // Hang guard: far above the hundred or so cycles the scenarios need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic access(input logic w, input logic [12:0] a, input logic [7:0] d);
      int n;
      n = 0;
      req_valid = 1'b1;
      req = {w, a, d};
      do begin @(posedge clk); #10; n++; end while (req_ready !== 1'b1 && n < 40);
      req_valid = 1'b0;
      `CHK(addr, a)
      if (w) begin
         `CHK({ctl_n, mem_oe}, 4'h4)
         `CHK({bus_oe, bus_out}, {1'b1, d})
      end else begin
         `CHK({ctl_n, mem_oe}, 4'h3)
         n = 0;
         do begin @(posedge clk); #10; n++; end while (rd_valid !== 1'b1 && n < 10);
         `CHK(rd_data, d)
      end
      repeat (3) @(posedge clk);
      #10;
      `CHK({ctl_n, bus_oe, req_ready, rd_valid}, 6'h38)
   endtask : access
   task automatic t_table();
      logic [12:0] a [4] = '{13'h0000, 13'h0001, 13'h0AAA, 13'h1FFF};
      for (int i = 0; i < 4; i++) begin
         access(1'b1, a[i], 8'hA0 + 8'(i));
         access(1'b0, a[i], 8'hA0 + 8'(i));
      end
      for (int i = 0; i < 4; i++) access(1'b0, a[i], 8'hA0 + 8'(i));
   endtask : t_table
   task automatic t_fault();
      int n;
      n = 0;
      req_valid = 1'b1;
      req = {1'b1, 13'h0001, 8'h5A};
      do begin @(posedge clk); #10; n++; end while (req_ready !== 1'b1 && n < 40);
      // Supply drops while this write's strobes are still low
      fault = 1'b1;
      req = {1'b1, 13'h1FFF, 8'h55};
      repeat (2) @(posedge clk);
      repeat (6) begin
         @(posedge clk);
         #10;
         `CHK({req_ready, ctl_n, bus_oe}, 5'h0E)
      end
      fault = 1'b0;
      n = 0;
      do begin @(posedge clk); #10; n++; end while (req_ready !== 1'b1 && n < 40);
      req_valid = 1'b0;
      `CHK(n >= 10, 1'b1)
      repeat (4) @(posedge clk);
      #10;
      access(1'b0, 13'h0AAA, 8'hA2);
      access(1'b0, 13'h0000, 8'hA0);
      access(1'b0, 13'h1FFF, 8'h55);
   endtask : t_fault
   initial begin
      repeat (3) @(posedge clk);
      #10;
      `CHK({ctl_n, bus_oe, req_ready, rd_valid}, 6'h38)
      rst_n = 1'b1;
      t_table();
      t_fault();
      print_verdict();
   end
endmodule : battery_backed_async_sram_port_test
